// ---- include/mcuid_pkg.sv ----
/*
  Shared constants and types for the instruction decoder and cycle sequencer.
  Assumes a single 200 MHz core clock and a synchronous active-low reset.
*/
package mcuid_pkg;

  // Instruction cycle framing
  localparam int unsigned CLKS_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] MOVX_BASE_CYCLES = 4'h2;

  // Clock control byte: stretch field position and reset value
  localparam int unsigned STRETCH_LSB = 0;
  localparam int unsigned STRETCH_W = 3;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;

  // Cycle counts and byte lengths
  localparam logic [3:0] CYC1 = 4'h1;
  localparam logic [3:0] CYC2 = 4'h2;
  localparam logic [3:0] CYC3 = 4'h3;
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_ALU = 4'h1,
    CLS_MOVE = 4'h2,
    CLS_MOVC = 4'h3,
    CLS_MOVX = 4'h4,
    CLS_PUSH = 4'h5,
    CLS_POP = 4'h6,
    CLS_XCH = 4'h7,
    CLS_DATA_POINTER_16 = 4'h8
  } mcuid_class_t;

  typedef enum logic [3:0] {
    ALU_NOP = 4'h0,
    ALU_ADD = 4'h1,
    ALU_ADDC = 4'h2,
    ALU_SUBB = 4'h3,
    ALU_AND = 4'h4,
    ALU_OR = 4'h5,
    ALU_XOR = 4'h6,
    ALU_CLR = 4'h7,
    ALU_CPL = 4'h8,
    ALU_SWAP = 4'h9,
    ALU_RL = 4'hA,
    ALU_RLC = 4'hB,
    ALU_RR = 4'hC,
    ALU_RRC = 4'hD
  } mcuid_alu_t;

  typedef enum logic [3:0] {
    OPD_NONE = 4'h0,
    OPD_ACC = 4'h1,
    OPD_REG = 4'h2,
    OPD_IND = 4'h3,
    OPD_DIR = 4'h4,
    OPD_IMM = 4'h5,
    OPD_IMM16 = 4'h6,
    OPD_DATA_POINTER_16 = 4'h7,
    OPD_CODE_DATA_POINTER_16 = 4'h8,
    OPD_CODE_PC = 4'h9,
    OPD_EXT8 = 4'hA,
    OPD_EXT16 = 4'hB,
    OPD_STACK = 4'hC
  } mcuid_opd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } mcuid_state_t;

endpackage : mcuid_pkg

// ---- rtl/mcuid_cycle_timer.sv ----
/*
  Clock phase counter inside one instruction cycle.
  Assumes run is driven by the sequencer on the same clock.
*/
module mcuid_cycle_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic [1:0] phase,
  output logic cycle_end
);

  logic [1:0] phase_q;
  logic [1:0] phase_d;

  // Phase restarts at zero whenever the sequencer is idle
  always_comb begin
    phase_d = run ? phase_q + 2'h1 : 2'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
  assign cycle_end = run && (phase_q == mcuid_pkg::PHASE_LAST);

endmodule : mcuid_cycle_timer

// ---- rtl/mcuid_decoder.sv ----
/*
  Opcode decoder and instruction cycle sequencer for the arithmetic, logical
  and data-transfer groups. Assumes opcode and operand bytes come from the
  fetch logic on the same clock and are held while op_valid is high.
*/
// Function
// - Every instruction cycle lasts four clocks; cycle counts use this unit.
// - Add decodes 28-2F, 26-27 one cycle; 25, 24 two bytes two cycles.
// - Add-with-carry decodes 38-3F, 36-37, 35, 34 and uses carry.
// - Subtract-with-borrow decodes 98-9F, 96-97, 95, 94 and uses carry.
// - AND decodes 58-5F, 56-57, 54, 52 (two cycles), 53 (three).
// - OR decodes 48-4F, 46-47, 45, 44, 42 two bytes two cycles, 43 three bytes three cycles.
// - XOR decodes 68-6F, 66-67, 65, 64, 62 two bytes two cycles, 63 three bytes three cycles.
// - One-cycle accumulator ops: E4, F4, C4, 23, 33, 03, 13.
// - Moves to A: E8-EF, E6-E7, E5, 74; from A: F8-FF, F6-F7, F5.
// - Register loads A8-AF, 78-7F two cycles; direct from 88-8F, 86-87.
// - Moves 85 and 75 take three bytes three cycles; A6-A7, 76-77 indirect.
// - Data pointer immediate load 90 takes three bytes three cycles.
// - Code reads 93 and 83 are one byte, three cycles.
// - External transfers E2-E3, E0, F2-F3, F0 are one byte, 2-9 cycles.
// - Push C0 and pop D0 are two bytes two cycles.
// - Exchange C8-CF, C6-C7 one cycle; C5 two bytes two cycles.
// - Lowest opcode bit picks pointer register 0 or 1 for indirect forms.
// - Relative operand is signed 8-bit; immediates are 8 or 16 bits.
// - External transfer cycles equal two plus stretch field, reset value 1.
module mcuid_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic clock_control_wr,
  input wire logic [7:0] clock_control_wdata,
  output logic [7:0] clock_control_sfr,
  output mcuid_pkg::mcuid_class_t dec_class,
  output mcuid_pkg::mcuid_alu_t dec_alu,
  output mcuid_pkg::mcuid_opd_t dec_src,
  output mcuid_pkg::mcuid_opd_t dec_dst,
  output logic [1:0] dec_len,
  output logic [3:0] dec_cycles,
  output logic indirect_pointer_reg,
  output logic dec_uses_carry,
  output logic dec_unsupported,
  output logic [15:0] dec_imm16,
  output logic [15:0] dec_rel,
  output logic busy,
  output logic [1:0] clk_phase,
  output logic [3:0] cycle_index,
  output logic exec_done
);

  logic [7:0] clock_control_sfr_q, clock_control_sfr_d;
  logic [2:0] movx_stretch_field;
  mcuid_pkg::mcuid_class_t cls_c, cls_q;
  mcuid_pkg::mcuid_alu_t alu_c, alu_q;
  mcuid_pkg::mcuid_opd_t src_c, src_q, dst_c, dst_q;
  logic [1:0] len_c, len_q;
  logic [3:0] cyc_c, cyc_q;
  logic ptr_q, carry_q, unsup_q;
  logic [15:0] imm16_q, rel_q;
  mcuid_pkg::mcuid_state_t state_q, state_d;
  logic [3:0] cidx_q, cidx_d;
  logic done_q, done_d;
  logic accept, cycle_end;
  logic [1:0] phase;

  // Software writes the stretch value through the clock control byte
  always_comb begin
    clock_control_sfr_d = clock_control_wr ? clock_control_wdata : clock_control_sfr_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_control_sfr_q <= mcuid_pkg::CLOCK_CONTROL_RESET;
    end else begin
      clock_control_sfr_q <= clock_control_sfr_d;
    end
  end

  assign movx_stretch_field =
    clock_control_sfr_q[mcuid_pkg::STRETCH_LSB +: mcuid_pkg::STRETCH_W];
  assign clock_control_sfr = clock_control_sfr_q;

  always_comb begin
    cls_c = mcuid_pkg::CLS_NONE;
    alu_c = mcuid_pkg::ALU_NOP;
    src_c = mcuid_pkg::OPD_NONE;
    dst_c = mcuid_pkg::OPD_NONE;
    len_c = mcuid_pkg::LEN1;
    cyc_c = mcuid_pkg::CYC1;
    casez (opcode)
      8'h23, 8'h33, 8'h03, 8'h13, 8'hE4, 8'hF4, 8'hC4: begin
        cls_c = mcuid_pkg::CLS_ALU;
        src_c = mcuid_pkg::OPD_ACC;
        dst_c = mcuid_pkg::OPD_ACC;
        case (opcode)
          8'h23: alu_c = mcuid_pkg::ALU_RL;
          8'h33: alu_c = mcuid_pkg::ALU_RLC;
          8'h03: alu_c = mcuid_pkg::ALU_RR;
          8'h13: alu_c = mcuid_pkg::ALU_RRC;
          8'hE4: alu_c = mcuid_pkg::ALU_CLR;
          8'hF4: alu_c = mcuid_pkg::ALU_CPL;
          default: alu_c = mcuid_pkg::ALU_SWAP;
        endcase
      end
      8'h90: begin
        cls_c = mcuid_pkg::CLS_DATA_POINTER_16;
        src_c = mcuid_pkg::OPD_IMM16;
        dst_c = mcuid_pkg::OPD_DATA_POINTER_16;
        len_c = mcuid_pkg::LEN3;
        cyc_c = mcuid_pkg::CYC3;
      end
      8'h93, 8'h83: begin
        cls_c = mcuid_pkg::CLS_MOVC;
        src_c = opcode[4] ? mcuid_pkg::OPD_CODE_DATA_POINTER_16 : mcuid_pkg::OPD_CODE_PC;
        dst_c = mcuid_pkg::OPD_ACC;
        cyc_c = mcuid_pkg::CYC3;
      end
      8'hE0, 8'b1110_001?, 8'hF0, 8'b1111_001?: begin
        cls_c = mcuid_pkg::CLS_MOVX;
        // Stretch is sampled at accept; a later write affects the next transfer
        cyc_c = mcuid_pkg::MOVX_BASE_CYCLES + {1'b0, movx_stretch_field};
        if (opcode[4]) begin
          src_c = mcuid_pkg::OPD_ACC;
          dst_c = opcode[1] ? mcuid_pkg::OPD_EXT8 : mcuid_pkg::OPD_EXT16;
        end else begin
          src_c = opcode[1] ? mcuid_pkg::OPD_EXT8 : mcuid_pkg::OPD_EXT16;
          dst_c = mcuid_pkg::OPD_ACC;
        end
      end
      8'hC0, 8'hD0: begin
        cls_c = opcode[4] ? mcuid_pkg::CLS_POP : mcuid_pkg::CLS_PUSH;
        src_c = opcode[4] ? mcuid_pkg::OPD_STACK : mcuid_pkg::OPD_DIR;
        dst_c = opcode[4] ? mcuid_pkg::OPD_DIR : mcuid_pkg::OPD_STACK;
        len_c = mcuid_pkg::LEN2;
        cyc_c = mcuid_pkg::CYC2;
      end
      8'b1100_1???, 8'b1100_011?, 8'hC5: begin
        cls_c = mcuid_pkg::CLS_XCH;
        dst_c = mcuid_pkg::OPD_ACC;
        if (opcode[3]) begin
          src_c = mcuid_pkg::OPD_REG;
        end else if (opcode[1]) begin
          src_c = mcuid_pkg::OPD_IND;
        end else begin
          src_c = mcuid_pkg::OPD_DIR;
          len_c = mcuid_pkg::LEN2;
          cyc_c = mcuid_pkg::CYC2;
        end
      end
      8'b0010_????, 8'b0011_????, 8'b1001_????,
      8'b0100_????, 8'b0101_????, 8'b0110_????: begin
        cls_c = mcuid_pkg::CLS_ALU;
        dst_c = mcuid_pkg::OPD_ACC;
        case (opcode[7:4])
          4'h2: alu_c = mcuid_pkg::ALU_ADD;
          4'h3: alu_c = mcuid_pkg::ALU_ADDC;
          4'h9: alu_c = mcuid_pkg::ALU_SUBB;
          4'h5: alu_c = mcuid_pkg::ALU_AND;
          4'h4: alu_c = mcuid_pkg::ALU_OR;
          default: alu_c = mcuid_pkg::ALU_XOR;
        endcase
        if (opcode[3]) begin
          src_c = mcuid_pkg::OPD_REG;
        end else begin
          case (opcode[2:0])
            3'h6, 3'h7: src_c = mcuid_pkg::OPD_IND;
            3'h5: begin
              src_c = mcuid_pkg::OPD_DIR;
              len_c = mcuid_pkg::LEN2;
              cyc_c = mcuid_pkg::CYC2;
            end
            3'h4: begin
              src_c = mcuid_pkg::OPD_IMM;
              len_c = mcuid_pkg::LEN2;
              cyc_c = mcuid_pkg::CYC2;
            end
            3'h2, 3'h3: begin
              // Only the logical groups have direct-byte destinations
              if (opcode[7:6] == 2'h1) begin
                dst_c = mcuid_pkg::OPD_DIR;
                src_c = opcode[0] ? mcuid_pkg::OPD_IMM : mcuid_pkg::OPD_ACC;
                len_c = opcode[0] ? mcuid_pkg::LEN3 : mcuid_pkg::LEN2;
                cyc_c = opcode[0] ? mcuid_pkg::CYC3 : mcuid_pkg::CYC2;
              end else begin
                cls_c = mcuid_pkg::CLS_NONE;
                alu_c = mcuid_pkg::ALU_NOP;
                dst_c = mcuid_pkg::OPD_NONE;
              end
            end
            default: begin
              cls_c = mcuid_pkg::CLS_NONE;
              alu_c = mcuid_pkg::ALU_NOP;
              dst_c = mcuid_pkg::OPD_NONE;
            end
          endcase
        end
      end
      8'b1110_1???, 8'b1110_011?, 8'hE5, 8'h74,
      8'b1111_1???, 8'b1111_011?, 8'hF5: begin
        cls_c = mcuid_pkg::CLS_MOVE;
        // Bit 4 cannot give the direction here: 74 loads the accumulator
        if (opcode[7:4] == 4'hF) begin
          src_c = mcuid_pkg::OPD_ACC;
          dst_c = opcode[3] ? mcuid_pkg::OPD_REG :
                  (opcode[1] ? mcuid_pkg::OPD_IND : mcuid_pkg::OPD_DIR);
        end else begin
          dst_c = mcuid_pkg::OPD_ACC;
          src_c = opcode[3] ? mcuid_pkg::OPD_REG :
                  (opcode[1] ? mcuid_pkg::OPD_IND :
                  (opcode[7] ? mcuid_pkg::OPD_DIR : mcuid_pkg::OPD_IMM));
        end
        if (!opcode[3] && !opcode[1]) begin
          len_c = mcuid_pkg::LEN2;
          cyc_c = mcuid_pkg::CYC2;
        end
      end
      8'b1010_1???, 8'b0111_1???, 8'b1000_1???, 8'b1000_011?,
      8'b1010_011?, 8'b0111_011?: begin
        cls_c = mcuid_pkg::CLS_MOVE;
        len_c = mcuid_pkg::LEN2;
        cyc_c = mcuid_pkg::CYC2;
        if (opcode[7:4] == 4'h8) begin
          dst_c = mcuid_pkg::OPD_DIR;
          src_c = opcode[3] ? mcuid_pkg::OPD_REG : mcuid_pkg::OPD_IND;
        end else begin
          dst_c = opcode[3] ? mcuid_pkg::OPD_REG : mcuid_pkg::OPD_IND;
          src_c = opcode[7] ? mcuid_pkg::OPD_DIR : mcuid_pkg::OPD_IMM;
        end
      end
      8'h85, 8'h75: begin
        cls_c = mcuid_pkg::CLS_MOVE;
        dst_c = mcuid_pkg::OPD_DIR;
        src_c = opcode[7] ? mcuid_pkg::OPD_DIR : mcuid_pkg::OPD_IMM;
        len_c = mcuid_pkg::LEN3;
        cyc_c = mcuid_pkg::CYC3;
      end
      default: cls_c = mcuid_pkg::CLS_NONE;
    endcase
  end

  assign accept = op_valid && op_ready;

  mcuid_cycle_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_q == mcuid_pkg::ST_EXEC),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  always_comb begin
    state_d = state_q;
    cidx_d = cidx_q;
    done_d = 1'b0;
    case (state_q)
      mcuid_pkg::ST_IDLE: begin
        cidx_d = 4'h0;
        if (op_valid) begin
          state_d = mcuid_pkg::ST_EXEC;
        end
      end
      mcuid_pkg::ST_EXEC: begin
        if (cycle_end) begin
          if (cidx_q == cyc_q - 4'h1) begin
            state_d = mcuid_pkg::ST_IDLE;
            done_d = 1'b1;
            cidx_d = 4'h0;
          end else begin
            cidx_d = cidx_q + 4'h1;
          end
        end
      end
      default: state_d = mcuid_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= mcuid_pkg::ST_IDLE;
      cidx_q <= 4'h0;
      done_q <= 1'b0;
      cls_q <= mcuid_pkg::CLS_NONE;
      alu_q <= mcuid_pkg::ALU_NOP;
      src_q <= mcuid_pkg::OPD_NONE;
      dst_q <= mcuid_pkg::OPD_NONE;
      len_q <= mcuid_pkg::LEN1;
      cyc_q <= mcuid_pkg::CYC1;
      ptr_q <= 1'b0;
      carry_q <= 1'b0;
      unsup_q <= 1'b0;
      imm16_q <= 16'h0000;
      rel_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cidx_q <= cidx_d;
      done_q <= done_d;
      if (accept) begin
        cls_q <= cls_c;
        alu_q <= alu_c;
        src_q <= src_c;
        dst_q <= dst_c;
        len_q <= len_c;
        cyc_q <= cyc_c;
        ptr_q <= opcode[0];
        carry_q <= (alu_c == mcuid_pkg::ALU_ADDC) || (alu_c == mcuid_pkg::ALU_SUBB) ||
                   (alu_c == mcuid_pkg::ALU_RLC) || (alu_c == mcuid_pkg::ALU_RRC);
        unsup_q <= (cls_c == mcuid_pkg::CLS_NONE);
        imm16_q <= {operand1, operand2};
        rel_q <= {{8{operand1[7]}}, operand1};
      end
    end
  end

  assign op_ready = (state_q == mcuid_pkg::ST_IDLE);
  assign busy = (state_q == mcuid_pkg::ST_EXEC);
  assign exec_done = done_q;
  assign clk_phase = phase;
  assign cycle_index = cidx_q;
  assign dec_class = cls_q;
  assign dec_alu = alu_q;
  assign dec_src = src_q;
  assign dec_dst = dst_q;
  assign dec_len = len_q;
  assign dec_cycles = cyc_q;
  assign indirect_pointer_reg = ptr_q;
  assign dec_uses_carry = carry_q;
  assign dec_unsupported = unsup_q;
  assign dec_imm16 = imm16_q;
  assign dec_rel = rel_q;

  // Clock count of the running instruction, read only by the checks
  logic [5:0] exec_clks_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !busy) begin
      exec_clks_q <= 6'h00;
    end else begin
      exec_clks_q <= exec_clks_q + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  exec_length_a: assert property ($rose(busy) |-> busy [*4] ##1 (busy || exec_done))
    else $error("instruction cycle shorter than four clocks");
  done_clocks_a: assert property ($rose(exec_done) |->
    $past(exec_clks_q) + 6'h01 == {cyc_q, 2'h0}) else $error("bad execution length");
  add_decode_a: assert property (accept && opcode[7:3] == 5'h05 |=>
    alu_q == mcuid_pkg::ALU_ADD && len_q == 2'h1 && cyc_q == 4'h1) else $error("add");
  addc_direct_a: assert property (accept && opcode == 8'h35 |=>
    alu_q == mcuid_pkg::ALU_ADDC && len_q == 2'h2 && carry_q) else $error("addc direct");
  subb_imm_a: assert property (accept && opcode == 8'h94 |=>
    alu_q == mcuid_pkg::ALU_SUBB && src_q == mcuid_pkg::OPD_IMM && cyc_q == 4'h2 && carry_q)
    else $error("subb");
  and_direct_a: assert property (accept && opcode == 8'h55 |=>
    alu_q == mcuid_pkg::ALU_AND && src_q == mcuid_pkg::OPD_DIR && cyc_q == 4'h2)
    else $error("and direct");
  logic_imm_dir_a: assert property (accept && opcode inside {8'h43, 8'h53, 8'h63} |=>
    dst_q == mcuid_pkg::OPD_DIR && len_q == 2'h3 && cyc_q == 4'h3)
    else $error("logic to direct");
  movx_cycles_a: assert property (accept && opcode == 8'hE0 |=>
    cyc_q == 4'h2 + {1'b0, $past(movx_stretch_field)}) else $error("movx cycles");
  ptr_select_a: assert property (accept && opcode[7:1] == 7'h73 |=>
    indirect_pointer_reg == $past(opcode[0])) else $error("pointer select");
  rel_sign_a: assert property (accept |=> dec_rel[15:8] == {8{$past(operand1[7])}})
    else $error("relative sign");
  data_pointer_16_load_a: assert property (accept && opcode == 8'h90 |=>
    cls_q == mcuid_pkg::CLS_DATA_POINTER_16 && len_q == 2'h3 ##1 busy [*8]) else $error("data_pointer_16 load");

  movx_run_c: cover property (accept && cls_c == mcuid_pkg::CLS_MOVX ##[8:40] exec_done);
  back_to_back_c: cover property (exec_done && accept);
  three_cycle_c: cover property (accept && cyc_c == 4'h3 ##13 exec_done);

endmodule : mcuid_decoder

// ---- verif/mcuid_fetch_model.sv ----
/*
  Behavioural fetch side: program memory handing opcode and operand bytes
  to the decoder. Assumes the bench fills queue_q and that op_ready is
  sampled on the rising edge of clk.
*/
module mcuid_fetch_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode,
  output logic [7:0] operand1,
  output logic [7:0] operand2
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] queue_q[$];
  logic taken;
  logic rst_seen;
  int wait_q;

  // Released bytes show the inverse of the last value, never a stale copy
  task automatic drop();
    op_valid = 1'b0;
    opcode = ~opcode;
    operand1 = ~operand1;
    operand2 = ~operand2;
  endtask : drop

  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    wait_q = 0;
    forever begin
      @(posedge clk);
      taken = op_valid && (op_ready === 1'b1);
      rst_seen = rst_n;
      #1;
      if (rst_seen !== 1'b1) begin
        queue_q.delete();
        wait_q = 0;
        if (op_valid) drop();
      end else if (op_valid && !taken) begin
        wait_q = wait_q;
      end else if (queue_q.size() > 0 && wait_q == 0) begin
        {opcode, operand1, operand2} = queue_q.pop_front();
        op_valid = 1'b1;
        // Random gaps mix back-to-back offers with slow ones
        wait_q = $urandom_range(2, 0);
      end else begin
        if (op_valid) drop();
        if (wait_q > 0) wait_q--;
      end
    end
  end
endmodule : mcuid_fetch_model

// ---- verif/test_mcu_core_instruction_decode.sv ----
/*
  Self-checking bench for the opcode decoder: every opcode, every stretch
  value, a random stream and a mid-run reset. Assumes the fetch model.
*/
module test_mcu_core_instruction_decode;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, op_valid, op_ready, clock_control_wr;
  logic [7:0] opcode, operand1, operand2, clock_control_wdata, clock_control_sfr;
  mcuid_pkg::mcuid_class_t dec_class;
  mcuid_pkg::mcuid_alu_t dec_alu;
  mcuid_pkg::mcuid_opd_t dec_src, dec_dst;
  logic [1:0] dec_len, clk_phase;
  logic [3:0] dec_cycles, cycle_index;
  logic indirect_pointer_reg, dec_uses_carry, dec_unsupported, busy, exec_done;
  logic [15:0] dec_imm16, dec_rel;
  int miscompares, checks, cycles, edges;
  logic pend;
  logic [7:0] t_op;
  logic [15:0] t_imm;
  logic [2:0] t_st;
  logic [6:0] e;

  mcuid_decoder i_dut (.clk, .rst_n, .op_valid, .op_ready, .opcode, .operand1, .operand2,
    .clock_control_wr, .clock_control_wdata, .clock_control_sfr, .dec_class, .dec_alu,
    .dec_src, .dec_dst, .dec_len, .dec_cycles, .indirect_pointer_reg, .dec_uses_carry,
    .dec_unsupported, .dec_imm16, .dec_rel, .busy, .clk_phase, .cycle_index, .exec_done);

  mcuid_fetch_model i_fetch (.clk, .rst_n, .op_ready, .op_valid, .opcode, .operand1,
    .operand2);

  // Returns {supported, length, cycles}; unsupported opcodes run one cycle
  function automatic logic [6:0] exp_dec(input logic [7:0] op, input logic [2:0] st);
    logic [3:0] h;
    logic [3:0] l;
    logic [6:0] mx;
    h = op[7:4];
    l = op[3:0];
    mx = {3'h5, 4'h2 + {1'b0, st}};
    if (l >= 4'h6) begin
      if (h inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE, 4'hF}) return 7'h51;
      if (h inside {4'h7, 4'h8, 4'hA}) return 7'h62;
      return 7'h01;
    end
    if (l == 4'h5 && h inside {4'h7, 4'h8}) return 7'h73;
    if (l == 4'h5 && h inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hE, 4'hF}) return 7'h62;
    if (l == 4'h4 && h inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9}) return 7'h62;
    if (l == 4'h4 && h inside {4'hC, 4'hE, 4'hF}) return 7'h51;
    if (l == 4'h3 && h <= 4'h3) return 7'h51;
    if (l[3:1] == 3'h1 && h inside {4'h4, 4'h5, 4'h6}) return l[0] ? 7'h73 : 7'h62;
    if (l == 4'h3 && h inside {4'h8, 4'h9}) return 7'h53;
    if (l[3:1] == 3'h1 && h inside {4'hE, 4'hF}) return mx;
    if (l == 4'h0 && h inside {4'hE, 4'hF}) return mx;
    if (l == 4'h0 && h == 4'h9) return 7'h73;
    if (l == 4'h0 && h inside {4'hC, 4'hD}) return 7'h62;
    return 7'h01;
  endfunction : exp_dec

  function automatic logic exp_carry(input logic [7:0] op);
    return (op[7:4] == 4'h3 && op[3:0] >= 4'h3) || (op[7:4] == 4'h9 && op[3:0] >= 4'h4)
      || op == 8'h13;
  endfunction : exp_carry

  function automatic mcuid_pkg::mcuid_alu_t exp_alu(input logic [7:0] op);
    case (op)
      8'hE4: return mcuid_pkg::ALU_CLR;
      8'hF4: return mcuid_pkg::ALU_CPL;
      8'hC4: return mcuid_pkg::ALU_SWAP;
      8'h23: return mcuid_pkg::ALU_RL;
      8'h33: return mcuid_pkg::ALU_RLC;
      8'h03: return mcuid_pkg::ALU_RR;
      8'h13: return mcuid_pkg::ALU_RRC;
      8'h55: return mcuid_pkg::ALU_AND;
      8'h35: return mcuid_pkg::ALU_ADDC;
      default: return mcuid_pkg::ALU_NOP;
    endcase
  endfunction : exp_alu

  // Returns {class, source, destination} for hand-picked forms; zero for the rest
  function automatic logic [11:0] exp_mode(input logic [7:0] op);
    case (op)
      8'h74: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_IMM, mcuid_pkg::OPD_ACC};
      8'hE5: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_DIR, mcuid_pkg::OPD_ACC};
      8'hF5: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_ACC, mcuid_pkg::OPD_DIR};
      8'hF6: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_ACC, mcuid_pkg::OPD_IND};
      8'h88: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_REG, mcuid_pkg::OPD_DIR};
      8'hA6: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_DIR, mcuid_pkg::OPD_IND};
      8'h75: return {mcuid_pkg::CLS_MOVE, mcuid_pkg::OPD_IMM, mcuid_pkg::OPD_DIR};
      8'h93: return {mcuid_pkg::CLS_MOVC, mcuid_pkg::OPD_CODE_DATA_POINTER_16, mcuid_pkg::OPD_ACC};
      8'h83: return {mcuid_pkg::CLS_MOVC, mcuid_pkg::OPD_CODE_PC, mcuid_pkg::OPD_ACC};
      8'hE0: return {mcuid_pkg::CLS_MOVX, mcuid_pkg::OPD_EXT16, mcuid_pkg::OPD_ACC};
      8'hF3: return {mcuid_pkg::CLS_MOVX, mcuid_pkg::OPD_ACC, mcuid_pkg::OPD_EXT8};
      8'hC0: return {mcuid_pkg::CLS_PUSH, mcuid_pkg::OPD_DIR, mcuid_pkg::OPD_STACK};
      8'hD0: return {mcuid_pkg::CLS_POP, mcuid_pkg::OPD_STACK, mcuid_pkg::OPD_DIR};
      8'h90: return {mcuid_pkg::CLS_DATA_POINTER_16, mcuid_pkg::OPD_IMM16, mcuid_pkg::OPD_DATA_POINTER_16};
      8'h53: return {mcuid_pkg::CLS_ALU, mcuid_pkg::OPD_IMM, mcuid_pkg::OPD_DIR};
      8'hC5: return {mcuid_pkg::CLS_XCH, mcuid_pkg::OPD_DIR, mcuid_pkg::OPD_ACC};
      default: return 12'h000;
    endcase
  endfunction : exp_mode

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic push(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    i_fetch.queue_q.push_back({op, a, b});
  endtask : push

  task automatic wait_idle();
    do begin
      @(posedge clk);
      #1;
    end while (i_fetch.queue_q.size() != 0 || pend || op_valid === 1'b1);
  endtask : wait_idle

  task automatic ctl_write(input logic [7:0] data);
    @(posedge clk);
    #1 clock_control_wr = 1'b1;
    clock_control_wdata = data;
    @(posedge clk);
    #1 clock_control_wr = 1'b0;
    check_val("stretch readback", {13'h0000, data[2:0]}, {13'h0000, clock_control_sfr[2:0]});
  endtask : ctl_write

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard, sized well above the roughly 4000 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      conclude();
    end
  end

  // Scoreboard: order is count, check the finishing opcode, then take a new one
  always @(posedge clk) begin
    if (rst_n !== 1'b1) begin
      pend = 1'b0;
    end else begin
      if (pend) edges++;
      if (pend && exec_done !== 1'b1) check_val("ready busy", 16'h0001, {op_ready, busy});
      // Cycle index and phase together count the clocks since the opcode was taken
      if (pend && exec_done !== 1'b1) begin
        check_val("phase", 16'(edges - 1), {10'h000, cycle_index, clk_phase});
      end
      if (pend && exec_done === 1'b1) begin
        e = exp_dec(t_op, t_st);
        check_val("done delay", {10'h000, e[3:0], 2'h0} + 16'h0001, 16'(edges));
        check_val("cycles", {12'h000, e[3:0]}, {12'h000, dec_cycles});
        check_val("unsupported", {15'h0000, !e[6]}, {15'h0000, dec_unsupported});
        if (e[6]) begin
          check_val("length", {14'h0000, e[5:4]}, {14'h0000, dec_len});
          check_val("carry use", {15'h0000, exp_carry(t_op)}, {15'h0000, dec_uses_carry});
        end
        if (e[6] && (t_op[3:1] == 3'h3 || (t_op[7:5] == 3'h7 && t_op[3:1] == 3'h1))) begin
          check_val("pointer", {15'h0000, t_op[0]}, {15'h0000, indirect_pointer_reg});
        end
        check_val("imm16", t_imm, dec_imm16);
        check_val("rel", {{8{t_imm[15]}}, t_imm[15:8]}, dec_rel);
        if (exp_alu(t_op) != mcuid_pkg::ALU_NOP) begin
          check_val("alu", 16'(exp_alu(t_op)), 16'(dec_alu));
        end
        if (!e[6] || exp_mode(t_op) != 12'h000) begin
          check_val("modes", 16'(exp_mode(t_op)), 16'({dec_class, dec_src, dec_dst}));
        end
        pend = 1'b0;
      end
      if (op_valid === 1'b1 && op_ready === 1'b1) begin
        t_op = opcode;
        t_imm = {operand1, operand2};
        t_st = clock_control_sfr[2:0];
        edges = 0;
        pend = 1'b1;
      end
    end
  end

  initial begin
    void'($urandom(32'hE091CA7B));
    rst_n = 1'b0;
    clock_control_wr = 1'b0;
    clock_control_wdata = 8'h00;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    edges = 0;
    pend = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    check_val("reset control", 16'h0001, {8'h00, clock_control_sfr});
    check_val("reset ready busy", 16'h0002, {op_ready, busy});
    $display("test reset done");
    // The fetch model flushes its queue while it still sees reset
    @(posedge clk);
    for (int i = 0; i < 256; i++) push(8'(i), 8'($urandom), 8'($urandom));
    wait_idle();
    $display("test opcode sweep done");
    for (int s = 0; s < 8; s++) begin
      ctl_write({5'($urandom), 3'(s)});
      push(8'hE0, 8'($urandom), 8'($urandom));
      push(8'hF3, 8'($urandom), 8'($urandom));
      wait_idle();
    end
    $display("test stretch sweep done");
    repeat (300) push(8'($urandom), 8'($urandom), 8'($urandom));
    wait_idle();
    $display("test random stream done");
    ctl_write(8'h07);
    push(8'hF0, 8'($urandom), 8'($urandom));
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 check_val("reset control", 16'h0001, {8'h00, clock_control_sfr});
    check_val("reset ready busy", 16'h0002, {op_ready, busy});
    rst_n = 1'b1;
    @(posedge clk);
    push(8'hE2, 8'($urandom), 8'($urandom));
    wait_idle();
    $display("test mid-run reset done");
    conclude();
  end
endmodule : test_mcu_core_instruction_decode
